// file: hdl/spifr_params.svh
// offsets, field positions, reset values and divider figures of the framed serial port
`ifndef SPIFR_PARAMS_SVH
`define SPIFR_PARAMS_SVH
`define SPIFR_OFS_STAT      8'h00
`define SPIFR_OFS_CON1      8'h04
`define SPIFR_OFS_CON2      8'h08
`define SPIFR_OFS_BUF       8'h0C
`define SPIFR_STAT_EN       15
`define SPIFR_STAT_SIDL     13
`define SPIFR_STAT_OVF      6
`define SPIFR_STAT_TXF      1
`define SPIFR_STAT_RXF      0
`define SPIFR_CON2_FRM      15
`define SPIFR_CON2_DIR      14
`define SPIFR_CON2_POL      13
`define SPIFR_CON2_DLY      1
`define SPIFR_CON1_WMASK    16'h1FFF
`define SPIFR_CON1_RESET    16'h0000
`define SPIFR_CON2_RESET    16'h0000
`define SPIFR_PRI_MAX_LOG2  6
`define SPIFR_SEC_BASE      4'h8
`define SPIFR_WORD_BITS     5'h10
`define SPIFR_BYTE_BITS     5'h08
`endif

// file: hdl/spifr_pkg.sv
// types of the framed serial port
package spifr_pkg;
	typedef enum logic [2:0] {
		M_IDLE  = 3'b001,
		M_PRE   = 3'b010,
		M_SHIFT = 3'b100
	} spifr_mstate_t;

	typedef struct packed {
		logic [2:0] unused;
		logic       clockPinDisable;
		logic       dataOutPinDisable;
		logic       wordWidthSelect;
		logic       samplePhase;
		logic       clockEdge;
		logic       selectPinEnable;
		logic       clockPolarity;
		logic       masterSelect;
		logic [2:0] secondaryPrescale;
		logic [1:0] primaryPrescale;
	} spifr_ctrl1_t;

	typedef struct packed {
		logic framedEnable;
		logic syncDirection;
		logic syncPolarity;
		logic syncEdge;
	} spifr_ctrl2_t;

	typedef struct packed {
		logic sckOut;
		logic sckOe;
		logic sdoOut;
		logic sdoOe;
		logic ssOut;
		logic ssOe;
	} spifr_pins_t;
endpackage

// file: hdl/spifr_core.sv
// framed master/slave serial port with apb register access
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "spifr_params.svh"

module spifr_core (
	// system
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic                  idleMode,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	// serial pins
	input  wire logic                  sckIn,
	input  wire logic                  sdiIn,
	input  wire logic                  ssInN,
	output spifr_pkg::spifr_pins_t     pins
);
	import spifr_pkg::*;

	spifr_ctrl1_t  ctrl1_q;
	spifr_ctrl2_t  ctrl2_q;
	spifr_mstate_t mState_q;
	spifr_pins_t   pins_d;
	logic        enable_q, idleStop_q, ovf_q, txFull_q, rxFull_q;
	logic [15:0] txBuf_q, rxBuf_q, shift_q;
	logic        pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic [9:0]  divCnt_q;
	logic [4:0]  hCnt_q, bitCnt_q;
	logic        inBit_q, pend_q, armed_q, sckPrev_q, ssPrev_q;
	logic [2:0]  sync0_q, sync1_q, sync2_q, filt_q;
	logic [2:0]  rawIn;

	// pin input filter: three stages, change taken when last two agree
	assign rawIn = {ssInN, sdiIn, sckIn};
	generate
		for (genvar i = 0; i < 3; i++) begin : g_filt
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					sync0_q[i] <= 1'b0;
					sync1_q[i] <= 1'b0;
					sync2_q[i] <= 1'b0;
					filt_q[i]  <= 1'b0;
				end else begin
					sync0_q[i] <= rawIn[i];
					sync1_q[i] <= sync0_q[i];
					sync2_q[i] <= sync1_q[i];
					if (sync1_q[i] == sync2_q[i])
						filt_q[i] <= sync2_q[i];
				end
			end
		end
	endgenerate

	logic sckF, sdiF, ssF;
	assign sckF = filt_q[0];
	assign sdiF = filt_q[1];
	assign ssF  = filt_q[2];

	// apb decode
	logic access, wrStat, wrCon1, wrCon2, wrBuf, rdBuf, mapped;
	assign access = psel & penable & pready_q;
	assign mapped = (paddr == `SPIFR_OFS_STAT) || (paddr == `SPIFR_OFS_CON1) ||
	                (paddr == `SPIFR_OFS_CON2) || (paddr == `SPIFR_OFS_BUF);
	assign wrStat = access & pwrite & (paddr == `SPIFR_OFS_STAT);
	assign wrCon1 = access & pwrite & (paddr == `SPIFR_OFS_CON1);
	assign wrCon2 = access & pwrite & (paddr == `SPIFR_OFS_CON2);
	assign wrBuf  = access & pwrite & (paddr == `SPIFR_OFS_BUF);
	assign rdBuf  = access & ~pwrite & (paddr == `SPIFR_OFS_BUF);

	// derived controls
	logic run, isMaster, framed, ckeEff, mRun, sRun;
	logic [4:0] nBits;
	assign run      = enable_q & ~(idleStop_q & idleMode);
	assign isMaster = ctrl1_q.masterSelect;
	assign framed   = ctrl2_q.framedEnable;
	assign ckeEff   = ctrl1_q.clockEdge & ~framed;
	assign mRun     = run & isMaster & ~ctrl1_q.clockPinDisable;
	assign sRun     = run & ~isMaster;
	assign nBits    = ctrl1_q.wordWidthSelect ? `SPIFR_WORD_BITS : `SPIFR_BYTE_BITS;

	// prescaler: primary 64/16/4/1, secondary 8..1
	logic [9:0] halfLen;
	logic [3:0] secDiv;
	logic [2:0] priLog;
	assign secDiv  = `SPIFR_SEC_BASE - {1'b0, ctrl1_q.secondaryPrescale};
	assign priLog  = 3'(`SPIFR_PRI_MAX_LOG2) - {ctrl1_q.primaryPrescale, 1'b0};
	assign halfLen = 10'({6'h00, secDiv} << priLog);
	logic halfTick;
	assign halfTick = (divCnt_q == halfLen - 10'h001);

	// master sequencer
	logic mStart, mShift, mSample, mDoneClk;
	assign mStart   = mRun & (mState_q == M_IDLE) & txFull_q;
	assign mShift   = mRun & (mState_q == M_SHIFT) & halfTick & hCnt_q[0];
	assign mSample  = mRun & (mState_q == M_SHIFT) & halfTick &
	                  (hCnt_q[0] == ctrl1_q.samplePhase);
	assign mDoneClk = mShift & (hCnt_q == {nBits[3:0], 1'b0} - 5'h01);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mState_q <= M_IDLE;
			divCnt_q <= 10'h000;
			hCnt_q   <= 5'h00;
		end else if (!mRun) begin
			if (!run || !isMaster) begin
				mState_q <= M_IDLE;
				divCnt_q <= 10'h000;
				hCnt_q   <= 5'h00;
			end
		end else begin
			case (mState_q)
				M_IDLE: begin
					divCnt_q <= 10'h000;
					hCnt_q   <= 5'h00;
					if (txFull_q)
						mState_q <= (framed & ~ctrl2_q.syncDirection &
						             ~ctrl2_q.syncEdge) ? M_PRE : M_SHIFT;
				end
				M_PRE: begin
					divCnt_q <= halfTick ? 10'h000 : divCnt_q + 10'h001;
					if (halfTick) begin
						hCnt_q <= hCnt_q[0] ? 5'h00 : 5'h01;
						if (hCnt_q[0])
							mState_q <= M_SHIFT;
					end
				end
				M_SHIFT: begin
					divCnt_q <= halfTick ? 10'h000 : divCnt_q + 10'h001;
					if (halfTick)
						hCnt_q <= hCnt_q + 5'h01;
					if (mDoneClk) begin
						mState_q <= M_IDLE;
						hCnt_q   <= 5'h00;
					end
				end
				default: mState_q <= M_IDLE;
			endcase
		end
	end

	// slave edge detection and framing
	logic sLead, sTrail, sChange, sSample, ssAct, frameGo, selOk, sAbort;
	assign sLead   = (sckF != sckPrev_q) & (sckPrev_q == ctrl1_q.clockPolarity);
	assign sTrail  = (sckF != sckPrev_q) & (sckPrev_q != ctrl1_q.clockPolarity);
	assign ssAct   = (ssF == ctrl2_q.syncPolarity);
	assign frameGo = framed & ctrl2_q.syncDirection &
	                 (ctrl2_q.syncEdge ? (ssAct & (ssPrev_q != ctrl2_q.syncPolarity))
	                                   : (~ssAct & (ssPrev_q == ctrl2_q.syncPolarity)));
	assign selOk   = framed ? (ctrl2_q.syncDirection ? armed_q : 1'b1)
	                        : (~ctrl1_q.selectPinEnable | ~ssF);
	assign sAbort  = sRun & ~framed & ctrl1_q.selectPinEnable & ssF;
	assign sChange = sRun & selOk & (ckeEff ? sTrail : sLead);
	assign sSample = sRun & selOk & (ckeEff ? sLead : sTrail);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sckPrev_q <= 1'b0;
			ssPrev_q  <= 1'b0;
		end else begin
			sckPrev_q <= sckF;
			ssPrev_q  <= ssF;
		end
	end

	// shared datapath, full duplex
	logic shiftEv, sampleEv, lastBit, complete, loadEv;
	logic [15:0] rxVal;
	assign shiftEv  = isMaster ? mShift : sChange;
	assign sampleEv = isMaster ? mSample : sSample;
	assign lastBit  = (bitCnt_q == nBits - 5'h01);
	assign complete = sampleEv & lastBit;
	assign loadEv   = isMaster ? mStart
	                           : (sRun & txFull_q & (bitCnt_q == 5'h00) & ~pend_q);
	assign rxVal    = ctrl1_q.wordWidthSelect ? {shift_q[14:0], sdiF}
	                                          : {8'h00, shift_q[6:0], sdiF};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			shift_q  <= 16'h0000;
			bitCnt_q <= 5'h00;
			inBit_q  <= 1'b0;
			pend_q   <= 1'b0;
		end else if (!enable_q || sAbort || mStart || (sRun && loadEv)) begin
			if (loadEv)
				shift_q <= txBuf_q;
			bitCnt_q <= 5'h00;
			pend_q   <= 1'b0;
		end else if (complete) begin
			bitCnt_q <= 5'h00;
			pend_q   <= 1'b0;
		end else if (sampleEv && shiftEv) begin
			shift_q  <= {shift_q[14:0], sdiF};
			bitCnt_q <= bitCnt_q + 5'h01;
		end else begin
			if (shiftEv && pend_q) begin
				shift_q <= {shift_q[14:0], inBit_q};
				pend_q  <= 1'b0;
			end
			if (sampleEv) begin
				inBit_q  <= sdiF;
				pend_q   <= 1'b1;
				bitCnt_q <= bitCnt_q + 5'h01;
			end
		end
	end

	// framed slave arming
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			armed_q <= 1'b0;
		else if (!enable_q || complete)
			armed_q <= 1'b0;
		else if (frameGo)
			armed_q <= 1'b1;
	end

	// control registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			enable_q   <= 1'b0;
			idleStop_q <= 1'b0;
			ctrl1_q    <= `SPIFR_CON1_RESET;
			ctrl2_q    <= 4'h0;
		end else begin
			if (wrStat) begin
				enable_q   <= pwdata[`SPIFR_STAT_EN];
				idleStop_q <= pwdata[`SPIFR_STAT_SIDL];
			end
			if (wrCon1)
				ctrl1_q <= pwdata[15:0] & `SPIFR_CON1_WMASK;
			if (wrCon2)
				ctrl2_q <= {pwdata[`SPIFR_CON2_FRM], pwdata[`SPIFR_CON2_DIR],
				            pwdata[`SPIFR_CON2_POL], pwdata[`SPIFR_CON2_DLY]};
		end
	end

	// buffers and flags, set wins over clear for transmit full and overflow only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			txBuf_q  <= 16'h0000;
			rxBuf_q  <= 16'h0000;
			txFull_q <= 1'b0;
			rxFull_q <= 1'b0;
			ovf_q    <= 1'b0;
		end else begin
			if (wrBuf)
				txBuf_q <= pwdata[15:0];
			txFull_q <= wrBuf | (txFull_q & ~loadEv);
			if (complete && !rxFull_q)
				rxBuf_q <= rxVal;
			rxFull_q <= (complete & ~rxFull_q) | (rxFull_q & ~rdBuf);
			ovf_q    <= (complete & rxFull_q) |
			            (ovf_q & ~(wrStat & ~pwdata[`SPIFR_STAT_OVF]));
		end
	end

	// apb answer, one wait state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pready_q  <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & ~mapped;
			case (paddr)
				`SPIFR_OFS_STAT: prdata_q <= {16'h0000, enable_q, 1'b0, idleStop_q, 6'h00,
				                              ovf_q, 4'h0, txFull_q, rxFull_q};
				`SPIFR_OFS_CON1: prdata_q <= {16'h0000, ctrl1_q};
				`SPIFR_OFS_CON2: prdata_q <= {16'h0000, ctrl2_q[3:1], 11'h000,
				                              ctrl2_q[0], 1'b0};
				`SPIFR_OFS_BUF:  prdata_q <= {16'h0000, rxBuf_q};
				default:         prdata_q <= 32'h00000000;
			endcase
		end
	end
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign prdata  = prdata_q;

	// pin drivers
	logic syncPulse;
	assign syncPulse = (mState_q == M_PRE) |
	                   ((mState_q == M_SHIFT) & ctrl2_q.syncEdge & (hCnt_q < 5'h02));
	always_comb begin
		pins_d        = '0;
		pins_d.sckOe  = enable_q & isMaster & ~ctrl1_q.clockPinDisable;
		pins_d.sckOut = (mState_q == M_IDLE) ? ctrl1_q.clockPolarity :
		                ctrl1_q.clockPolarity ^ (ckeEff ? hCnt_q[0] : ~hCnt_q[0]);
		pins_d.sdoOe  = enable_q & ~ctrl1_q.dataOutPinDisable;
		pins_d.sdoOut = ctrl1_q.wordWidthSelect ? shift_q[15] : shift_q[7];
		pins_d.ssOe   = enable_q & isMaster & framed & ~ctrl2_q.syncDirection;
		pins_d.ssOut  = syncPulse ? ctrl2_q.syncPolarity : ~ctrl2_q.syncPolarity;
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			pins <= '0;
		else
			pins <= pins_d;
	end

	// helper: samples taken in the current master transfer
	logic [4:0] sampCnt_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			sampCnt_q <= 5'h00;
		else if (mStart)
			sampCnt_q <= 5'h00;
		else if (mSample)
			sampCnt_q <= sampCnt_q + 5'h01;
	end

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_TXFULL_SET: assert property (wrBuf |=> txFull_q)
		else $error("transmit full not set by buffer write");
	AST_RXFULL_CLR: assert property (rdBuf && !complete |=> !rxFull_q)
		else $error("receive full not cleared by read");
	AST_OVF_SET: assert property (complete && rxFull_q && !rdBuf |=> ovf_q && $stable(rxBuf_q))
		else $error("overflow not flagged or data overwritten");
	AST_TXFULL_CLR: assert property (loadEv && !wrBuf |=> !txFull_q)
		else $error("transmit full not cleared by load");
	AST_PIN_RELEASE: assert property (!enable_q |=> !pins.sckOe && !pins.sdoOe && !pins.ssOe)
		else $error("pins still driven while disabled");
	AST_SCK_DIR: assert property (enable_q && !isMaster |=> !pins.sckOe)
		else $error("slave drives shift clock");
	AST_IDLE_FREEZE: assert property (enable_q && idleStop_q && idleMode && !wrStat
		|=> $stable(bitCnt_q) && $stable(hCnt_q))
		else $error("port moved while idle-stopped");
	AST_WIDTH: assert property (mDoneClk |-> sampCnt_q + {4'h0, mSample} == nBits)
		else $error("master transfer length wrong");
	AST_SCK_IDLE: assert property (mState_q == M_IDLE && !wrCon1
		|=> pins.sckOut == ctrl1_q.clockPolarity)
		else $error("idle clock level wrong");
	AST_SYNC_POL: assert property (pins.ssOe && mState_q == M_IDLE && !wrCon2
		|=> pins.ssOut == !ctrl2_q.syncPolarity)
		else $error("sync inactive level wrong");

	COV_MASTER_DONE: cover property (isMaster && complete);
	COV_SLAVE_DONE: cover property (!isMaster && complete);
	COV_OVERFLOW: cover property (complete && rxFull_q);
	COV_FRAMED: cover property (mState_q == M_PRE ##[1:600] mState_q == M_SHIFT);
	COV_IDLE_HOLD: cover property (enable_q && idleStop_q && idleMode && txFull_q);
endmodule // spifr_core

// file: bench/spifr_peer.sv
// far-side serial peripheral model answering the port in master use
`timescale 1ns/100ps
module spifr_peer (
	// serial lines
	input  wire logic        sckLine,
	input  wire logic        sdoLine,
	output logic             sdiLine,
	// test side
	input  wire logic        wordMode,
	input  wire logic [15:0] txWord,
	output logic [15:0]      rxWord
);
	logic [15:0] txReg;
	logic [4:0]  bitCnt;
	logic        inBit;
	initial begin
		txReg = 16'h0000;
		bitCnt = 5'h00;
		inBit = 1'h0;
		sdiLine = 1'h0;
		rxWord = 16'h0000;
	end
	// leading edge presents the next bit
	always @(posedge sckLine) begin
		if (bitCnt == 5'h00)
			txReg = wordMode ? txWord : {txWord[7:0], 8'h00};
		sdiLine = txReg[15];
		txReg = txReg << 1;
		inBit = 1'h1;
	end
	// trailing edge takes one bit in per bit out
	always @(negedge sckLine) begin
		if (inBit) begin
			rxWord = {rxWord[14:0], sdoLine};
			bitCnt = bitCnt + 5'h01;
			inBit = 1'h0;
		end
		if (bitCnt == (wordMode ? 5'h10 : 5'h08)) begin
			bitCnt = 5'h00;
			sdiLine = ~sdiLine;
		end
	end
endmodule // spifr_peer

// file: bench/spi_master_slave_framed_tb.sv
// self-checking bench for the framed serial port
`timescale 1ns/100ps
`include "spifr_params.svh"
module spi_master_slave_framed_tb;
	import spifr_pkg::*;
	logic        clock, rst, idleMode, psel, penable, pwrite, pready, pslverr, err;
	logic        sckLine, sdoLine, sdiLine, wordMode;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] txWord, rxWord;
	spifr_pins_t pins;
	int          bad_count, check_count;

	assign sckLine = pins.sckOe ? pins.sckOut : 1'h0;
	assign sdoLine = pins.sdoOe ? pins.sdoOut : 1'h1;

	spifr_core u_dut (.clock(clock), .rst(rst), .idleMode(idleMode), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .sckIn(sckLine), .sdiIn(sdiLine),
		.ssInN(pins.ssOe ? pins.ssOut : 1'h1), .pins(pins));
	spifr_peer u_peer (.sckLine(sckLine), .sdoLine(sdoLine), .sdiLine(sdiLine),
		.wordMode(wordMode), .txWord(txWord), .rxWord(rxWord));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
		if (n >= 20)
			chk("pready", 32'h1, 32'h0);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'h0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	task automatic waitBit(input int idx);
		int n;
		n = 0;
		do begin
			xfer(1'h0, `SPIFR_OFS_STAT, 32'h0);
			n++;
		end while (rd[idx] !== 1'h1 && n < 300);
	endtask
	task automatic regScenario;
		rdchk("stat reset", `SPIFR_OFS_STAT, 32'h0);
		rdchk("ctrl one reset", `SPIFR_OFS_CON1, 32'h0);
		rdchk("ctrl two reset", `SPIFR_OFS_CON2, 32'h0);
		xfer(1'h1, 8'h10, 32'hFFFF);
		chk("unmapped error", 32'h1, {31'h0, err});
		xfer(1'h1, `SPIFR_OFS_CON1, 32'hFFFFFFFE);
		rdchk("ctrl one fields", `SPIFR_OFS_CON1, 32'h1FFE);
		xfer(1'h1, `SPIFR_OFS_CON1, 32'h0);
		xfer(1'h1, `SPIFR_OFS_CON2, 32'hFFFF);
		rdchk("ctrl two fields", `SPIFR_OFS_CON2, 32'hE002);
		xfer(1'h1, `SPIFR_OFS_CON2, 32'h0);
	endtask
	task automatic wordScenario;
		txWord <= 16'h3C5A;
		wordMode <= 1'h1;
		xfer(1'h1, `SPIFR_OFS_CON1, 32'h0423);
		xfer(1'h1, `SPIFR_OFS_STAT, 32'h8000);
		xfer(1'h1, `SPIFR_OFS_BUF, 32'hA5C3);
		waitBit(0);
		chk("rx full", 32'h1, {31'h0, rd[0]});
		chk("tx full", 32'h0, {31'h0, rd[1]});
		chk("peer word", 32'hA5C3, {16'h0, rxWord});
		rdchk("buffer word", `SPIFR_OFS_BUF, 32'h3C5A);
		rdchk("rx full read", `SPIFR_OFS_STAT, 32'h8000);
	endtask
	task automatic overflowScenario;
		txWord <= 16'h1234;
		xfer(1'h1, `SPIFR_OFS_BUF, 32'h0001);
		waitBit(0);
		txWord <= 16'h5678;
		xfer(1'h1, `SPIFR_OFS_BUF, 32'h0002);
		waitBit(6);
		chk("overflow", 32'h1, {31'h0, rd[6]});
		rdchk("buffer kept", `SPIFR_OFS_BUF, 32'h1234);
		xfer(1'h1, `SPIFR_OFS_STAT, 32'h8000);
		rdchk("overflow cleared", `SPIFR_OFS_STAT, 32'h8000);
	endtask
	task automatic byteScenario;
		wordMode <= 1'h0;
		txWord <= 16'h00C6;
		xfer(1'h1, `SPIFR_OFS_CON1, 32'h0023);
		xfer(1'h1, `SPIFR_OFS_BUF, 32'hBE96);
		waitBit(0);
		chk("peer byte", 32'h96, {24'h0, rxWord[7:0]});
		xfer(1'h0, `SPIFR_OFS_BUF, 32'h0);
		chk("buffer byte", 32'hC6, {24'h0, rd[7:0]});
	endtask
	task automatic idleScenario;
		xfer(1'h1, `SPIFR_OFS_STAT, 32'hA000);
		idleMode <= 1'h1;
		xfer(1'h1, `SPIFR_OFS_BUF, 32'h0055);
		repeat (40) @(posedge clock);
		rdchk("idle frozen", `SPIFR_OFS_STAT, 32'hA002);
		idleMode <= 1'h0;
		waitBit(0);
		chk("idle resume", 32'h1, {31'h0, rd[0]});
		xfer(1'h0, `SPIFR_OFS_BUF, 32'h0);
	endtask
	task automatic settle;
		repeat (8) @(posedge clock);
	endtask
	task automatic pinScenario;
		xfer(1'h1, `SPIFR_OFS_CON1, 32'h1823);
		settle;
		chk("clock pin released", 32'h0, {31'h0, pins.sckOe});
		chk("data pin released", 32'h0, {31'h0, pins.sdoOe});
		xfer(1'h1, `SPIFR_OFS_CON1, 32'h0063);
		settle;
		chk("clock pin driven", 32'h1, {31'h0, pins.sckOe});
		chk("clock idle high", 32'h1, {31'h0, pins.sckOut});
		xfer(1'h1, `SPIFR_OFS_CON2, 32'h8000);
		settle;
		chk("sync driven", 32'h1, {31'h0, pins.ssOe});
		chk("sync idle low active", 32'h1, {31'h0, pins.ssOut});
		xfer(1'h1, `SPIFR_OFS_CON2, 32'hA000);
		settle;
		chk("sync idle high active", 32'h0, {31'h0, pins.ssOut});
		xfer(1'h1, `SPIFR_OFS_CON2, 32'hC000);
		settle;
		chk("sync input", 32'h0, {31'h0, pins.ssOe});
		xfer(1'h1, `SPIFR_OFS_CON2, 32'h0);
		xfer(1'h1, `SPIFR_OFS_CON1, 32'h0000);
		settle;
		chk("slave clock pin input", 32'h0, {31'h0, pins.sckOe});
		chk("slave data pin driven", 32'h1, {31'h0, pins.sdoOe});
		xfer(1'h1, `SPIFR_OFS_CON1, 32'h0023);
		xfer(1'h1, `SPIFR_OFS_STAT, 32'h0);
		settle;
		chk("disabled clock pin", 32'h0, {31'h0, pins.sckOe});
		chk("disabled data pin", 32'h0, {31'h0, pins.sdoOe});
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		rst = 1'h1;
		idleMode = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		txWord = 16'h0000;
		wordMode = 1'h1;
		bad_count = 0;
		check_count = 0;
		repeat (16) @(posedge clock);
		rst <= 1'h0;
		@(posedge clock);
		regScenario;
		wordScenario;
		overflowScenario;
		byteScenario;
		idleScenario;
		pinScenario;
		conclude;
	end
	initial begin
		#2000000;
		bad_count++;
		conclude;
	end
endmodule // spi_master_slave_framed_tb
